// File: map_ie_decoder.sv
// Modem end: decodes map elements into intervals with permitted frame formats
//
// How it works
// - Split element into 14/4/14 bit fields
// - Length is next offset minus own
// - Classify identifier broadcast/multicast/unicast/null
// - Every defined type decoded and acted on
// - Request interval allows request frames only
// - Headend uses multicast ids in request/data
// - Request/data packets ask for acknowledgement
// - Initial maintenance allows ranging requests only
// - Headend unicast initial maintenance on advanced-only
// - Station maintenance allows ranging request only
// - Zero-length data grant means grant pending
// - Headend sizes long grants above short
// - Pending and acknowledge follow the null
// - Acknowledge accepted only when one was asked
// - Expansion type recognised separately
// - Legacy modem never uses advanced grants
// - Headend picks codes by identifier, mode
// - Headend avoids 5/6 for advanced modems on mixed channels with advanced codes defined
// - Unsolicited grant never sizes requests
// - Headend grants unsolicited to advanced only
// - Times use only lower 26-M bits
// - Burst launched ranging offset early
`timescale 1ns/100ps
`default_nettype none
module map_ie_decoder (
	input wire logic sys_clk,
	input wire logic rst_n,
	alloc_map_if.modem link,
	input wire logic [13:0] own_sid,
	input wire logic legacy_mode,
	input wire logic ack_wanted,
	input wire logic [4:0] time_m,
	input wire logic [13:0] ranging_offset,
	output logic ivl_valid,
	output logic [13:0] ivl_sid,
	output logic [3:0] ivl_iuc,
	output logic [1:0] ivl_class,
	output logic [31:0] ivl_start,
	output logic [31:0] ivl_launch,
	output logic [13:0] ivl_len,
	output logic [3:0] ivl_fmt,
	output logic ivl_for_me,
	output logic ivl_ack_req,
	output logic ivl_sizes_req,
	output logic grant_pending,
	output logic data_acked,
	output logic expansion_seen,
	output logic [31:0] eff_map_start,
	output logic [31:0] eff_ack_time
);
	// ********************************************
	// Element fields
	// ********************************************
	logic [13:0] in_sid;
	logic [3:0] in_iuc;
	logic [13:0] in_ofs;
	logic have_prev;
	logic past_null;
	logic [13:0] prev_sid;
	logic [3:0] prev_iuc;
	logic [13:0] prev_ofs;
	logic [31:0] map_base;
	logic [31:0] time_mask;
	// Stray elements between maps are dropped
	logic map_open;
	wire take = link.ie_valid & link.ie_ready & map_open;

	assign link.ie_ready = 1'b1;
	assign in_sid = link.ie_word[alloc_map_pkg::SID_LSB +: alloc_map_pkg::SID_W];
	assign in_iuc = link.ie_word[alloc_map_pkg::IUC_LSB +: alloc_map_pkg::IUC_W];
	assign in_ofs = link.ie_word[alloc_map_pkg::OFS_LSB +: alloc_map_pkg::OFS_W];

	// Keep the lower 26-M bits of map times
	assign time_mask = 32'h03ff_ffff >> time_m;

	// ********************************************
	// Classification of the pending element
	// ********************************************
	function automatic logic [1:0] sid_class(input logic [13:0] s);
		if (s == alloc_map_pkg::SID_BCAST)
			return alloc_map_pkg::SID_CLS_BCAST;
		else if (s >= alloc_map_pkg::SID_MCAST_LO)
			return alloc_map_pkg::SID_CLS_MCAST;
		else if (s != alloc_map_pkg::SID_NONE)
			return alloc_map_pkg::SID_CLS_UCAST;
		return alloc_map_pkg::SID_CLS_NONE;
	endfunction : sid_class

	wire [1:0] prev_cls = sid_class(prev_sid);
	wire prev_mine = (prev_sid == own_sid) || prev_cls == alloc_map_pkg::SID_CLS_BCAST
		|| prev_cls == alloc_map_pkg::SID_CLS_MCAST;
	wire [13:0] prev_len = in_ofs - prev_ofs;
	wire prev_is_grant = prev_iuc == alloc_map_pkg::IUC_SHORT || prev_iuc == alloc_map_pkg::IUC_LONG
		|| prev_iuc == alloc_map_pkg::IUC_ADV_SHORT || prev_iuc == alloc_map_pkg::IUC_ADV_LONG;
	wire prev_is_adv = prev_iuc == alloc_map_pkg::IUC_ADV_SHORT || prev_iuc == alloc_map_pkg::IUC_ADV_LONG
		|| prev_iuc == alloc_map_pkg::IUC_ADV_UGS;
	// Interval is closed by the next element, so emit the previous one now
	wire emit = take & have_prev & ~past_null;

	logic [3:0] prev_fmt;
	always_comb begin
		prev_fmt = alloc_map_pkg::FMT_NONE;
		unique case (prev_iuc)
			alloc_map_pkg::IUC_REQ: prev_fmt = alloc_map_pkg::FMT_REQ;
			alloc_map_pkg::IUC_REQ_DATA: prev_fmt = alloc_map_pkg::FMT_REQ | alloc_map_pkg::FMT_DATA;
			alloc_map_pkg::IUC_INIT_MAINT: prev_fmt = alloc_map_pkg::FMT_RNG | alloc_map_pkg::FMT_INIT_RNG;
			alloc_map_pkg::IUC_STN_MAINT: prev_fmt = alloc_map_pkg::FMT_RNG;
			alloc_map_pkg::IUC_SHORT, alloc_map_pkg::IUC_LONG, alloc_map_pkg::IUC_ADV_SHORT,
				alloc_map_pkg::IUC_ADV_LONG, alloc_map_pkg::IUC_ADV_UGS: begin
				prev_fmt = alloc_map_pkg::FMT_REQ | alloc_map_pkg::FMT_DATA;
			end
			default: prev_fmt = alloc_map_pkg::FMT_NONE;
		endcase
		// Zero length grant: nothing may be sent
		if (prev_is_grant && prev_len == 14'h0000)
			prev_fmt = alloc_map_pkg::FMT_NONE;
		// Legacy modems stay off advanced intervals
		if (legacy_mode && prev_is_adv)
			prev_fmt = alloc_map_pkg::FMT_NONE;
	end

	// Elements after the null: only pending grants and acknowledgements matter
	wire tail_hit = take & past_null & (in_sid == own_sid);
	wire tail_pend = tail_hit & (in_iuc == alloc_map_pkg::IUC_SHORT || in_iuc == alloc_map_pkg::IUC_LONG
		|| in_iuc == alloc_map_pkg::IUC_ADV_SHORT || in_iuc == alloc_map_pkg::IUC_ADV_LONG);
	// An acknowledgement not asked for is dropped
	wire tail_ack = tail_hit & (in_iuc == alloc_map_pkg::IUC_DATA_ACK) & ack_wanted;
	wire [31:0] start_abs = (map_base + {18'h00000, prev_ofs}) & time_mask;

	// ********************************************
	// Map walk state
	// ********************************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			map_open <= 1'b0;
			have_prev <= 1'b0;
			past_null <= 1'b0;
			prev_sid <= 14'h0000;
			prev_iuc <= 4'h0;
			prev_ofs <= 14'h0000;
			map_base <= 32'h0000_0000;
			eff_map_start <= 32'h0000_0000;
			eff_ack_time <= 32'h0000_0000;
		end else begin
			if (link.map_start) begin
				have_prev <= 1'b0;
				past_null <= 1'b0;
				map_open <= 1'b1;
				map_base <= link.alloc_start;
				eff_map_start <= link.alloc_start & time_mask;
				eff_ack_time <= link.ack_time & time_mask;
			end else if (take) begin
				have_prev <= ~link.ie_last;
				map_open <= ~link.ie_last;
				if (in_iuc == alloc_map_pkg::IUC_NULL)
					past_null <= 1'b1;
				if (link.ie_last)
					past_null <= 1'b0;
				prev_sid <= in_sid;
				prev_iuc <= in_iuc;
				prev_ofs <= in_ofs;
			end
		end
	end

	// ********************************************
	// Interval output
	// ********************************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ivl_valid <= 1'b0;
			ivl_sid <= 14'h0000;
			ivl_iuc <= 4'h0;
			ivl_class <= 2'b00;
			ivl_start <= 32'h0000_0000;
			ivl_launch <= 32'h0000_0000;
			ivl_len <= 14'h0000;
			ivl_fmt <= 4'h0;
			ivl_for_me <= 1'b0;
			ivl_ack_req <= 1'b0;
			ivl_sizes_req <= 1'b0;
			grant_pending <= 1'b0;
			data_acked <= 1'b0;
			expansion_seen <= 1'b0;
		end else begin
			ivl_valid <= emit;
			grant_pending <= tail_pend | (emit & prev_is_grant & prev_mine & prev_len == 14'h0000);
			data_acked <= tail_ack;
			expansion_seen <= emit & (prev_iuc == alloc_map_pkg::IUC_EXPAND);
			if (emit) begin
				ivl_sid <= prev_sid;
				ivl_iuc <= prev_iuc;
				ivl_class <= prev_cls;
				ivl_start <= start_abs;
				// Early launch so the burst lands in its slot
				ivl_launch <= (start_abs - {18'h00000, ranging_offset}) & time_mask;
				ivl_len <= prev_len;
				ivl_fmt <= prev_mine ? prev_fmt : alloc_map_pkg::FMT_NONE;
				ivl_for_me <= prev_mine;
				ivl_ack_req <= prev_iuc == alloc_map_pkg::IUC_REQ_DATA;
				// Unsolicited grant profile is never a sizing reference
				ivl_sizes_req <= prev_is_grant & ~legacy_mode;
			end
		end
	end
endmodule : map_ie_decoder
`default_nettype wire

// File: alloc_map_pkg.sv
// Shared constants and types for the upstream allocation map link
package alloc_map_pkg;
	// ********************************************
	// Element layout
	// ********************************************
	localparam int SID_W = 14;
	localparam int IUC_W = 4;
	localparam int OFS_W = 14;
	localparam int IE_W = 32;
	localparam int SID_LSB = 18;
	localparam int IUC_LSB = 14;
	localparam int OFS_LSB = 0;
	localparam int TIME_W = 32;
	localparam int M_W = 5;
	localparam int LEN_W = 14;

	// ********************************************
	// Service identifier classes
	// ********************************************
	localparam logic [13:0] SID_BCAST = 14'h3fff;
	localparam logic [13:0] SID_MCAST_LO = 14'h2000;
	localparam logic [13:0] SID_UCAST_HI = 14'h1fff;
	localparam logic [13:0] SID_NONE = 14'h0000;

	// ********************************************
	// Interval type codes
	// ********************************************
	localparam logic [3:0] IUC_REQ = 4'h1;
	localparam logic [3:0] IUC_REQ_DATA = 4'h2;
	localparam logic [3:0] IUC_INIT_MAINT = 4'h3;
	localparam logic [3:0] IUC_STN_MAINT = 4'h4;
	localparam logic [3:0] IUC_SHORT = 4'h5;
	localparam logic [3:0] IUC_LONG = 4'h6;
	localparam logic [3:0] IUC_NULL = 4'h7;
	localparam logic [3:0] IUC_DATA_ACK = 4'h8;
	localparam logic [3:0] IUC_ADV_SHORT = 4'h9;
	localparam logic [3:0] IUC_ADV_LONG = 4'ha;
	localparam logic [3:0] IUC_ADV_UGS = 4'hb;
	localparam logic [3:0] IUC_EXPAND = 4'hf;

	typedef enum logic [1:0] {SID_CLS_NONE, SID_CLS_UCAST, SID_CLS_MCAST, SID_CLS_BCAST} sid_class_t;

	// Permitted frame formats, one bit each
	localparam int FMT_W = 4;
	localparam logic [3:0] FMT_NONE = 4'h0;
	localparam logic [3:0] FMT_REQ = 4'h1;
	localparam logic [3:0] FMT_DATA = 4'h2;
	localparam logic [3:0] FMT_RNG = 4'h4;
	localparam logic [3:0] FMT_INIT_RNG = 4'h8;
endpackage : alloc_map_pkg

// File: alloc_map_if.sv
// Link carrying map elements from the headend scheduler to the modem
`timescale 1ns/100ps
`default_nettype none
interface alloc_map_if;
	logic map_start;
	logic [31:0] alloc_start;
	logic [31:0] ack_time;
	logic ie_valid;
	logic ie_ready;
	logic [31:0] ie_word;
	logic ie_last;

	modport headend (output map_start, output alloc_start, output ack_time, output ie_valid, input ie_ready,
		output ie_word, output ie_last);
	modport modem (input map_start, input alloc_start, input ack_time, input ie_valid, output ie_ready,
		input ie_word, input ie_last);
endinterface : alloc_map_if
`default_nettype wire

// File: map_ie_scheduler.sv
// Headend end: issues map elements under the allocation constraints
`timescale 1ns/100ps
`default_nettype none
module map_ie_scheduler (
	input wire logic sys_clk,
	input wire logic rst_n,
	alloc_map_if.headend link,
	input wire logic new_map,
	input wire logic [31:0] alloc_start_in,
	input wire logic [31:0] ack_time_in,
	input wire logic [4:0] time_m,
	input wire logic el_valid,
	output logic el_ready,
	input wire logic [13:0] el_sid,
	input wire logic [3:0] el_iuc,
	input wire logic [13:0] el_ofs,
	input wire logic el_last,
	input wire logic adv_only_upstream,
	input wire logic mixed_channel,
	input wire logic cm_advanced,
	input wire logic adv_codes_defined,
	input wire logic short_defined,
	input wire logic [13:0] short_max,
	input wire logic [13:0] el_len,
	output logic el_reject
);
	logic [31:0] time_mask;
	logic after_null;
	logic [13:0] last_ofs;
	assign time_mask = 32'h03ff_ffff >> time_m;
	wire is_ucast = el_sid != alloc_map_pkg::SID_NONE && el_sid <= alloc_map_pkg::SID_UCAST_HI;
	wire is_mcast = el_sid >= alloc_map_pkg::SID_MCAST_LO && el_sid != alloc_map_pkg::SID_BCAST;
	wire legacy_code = el_iuc == alloc_map_pkg::IUC_SHORT || el_iuc == alloc_map_pkg::IUC_LONG;
	wire adv_code = el_iuc == alloc_map_pkg::IUC_ADV_SHORT || el_iuc == alloc_map_pkg::IUC_ADV_LONG;

	// ********************************************
	// Headend-side element checks
	// ********************************************
	wire bad_reqdata = el_iuc == alloc_map_pkg::IUC_REQ_DATA && !is_mcast;
	wire bad_init = el_iuc == alloc_map_pkg::IUC_INIT_MAINT && is_ucast && !adv_only_upstream;
	wire bad_long = el_iuc == alloc_map_pkg::IUC_LONG && short_defined && el_len != 14'h0000
		&& el_len <= short_max;
	wire bad_mix = mixed_channel && ((cm_advanced && legacy_code && adv_codes_defined)
		|| (!cm_advanced && adv_code));
	wire bad_ugs = el_iuc == alloc_map_pkg::IUC_ADV_UGS && !cm_advanced;
	// Tracked per map so a misordered list never reaches the modems
	wire bad_order = !after_null && el_ofs < last_ofs;
	wire bad_close = el_last && !after_null && el_iuc != alloc_map_pkg::IUC_NULL;
	wire bad_tail = after_null && !(legacy_code || adv_code || el_iuc == alloc_map_pkg::IUC_DATA_ACK);
	wire bad = bad_reqdata | bad_init | bad_long | bad_mix | bad_ugs | bad_order | bad_close | bad_tail;
	wire sent = el_valid & ~bad & link.ie_ready;

	assign el_ready = link.ie_ready;
	assign link.ie_valid = el_valid & ~bad;
	assign link.ie_word = {el_sid, el_iuc, el_ofs};
	assign link.ie_last = el_last;
	assign el_reject = el_valid & bad;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			link.map_start <= 1'b0;
			link.alloc_start <= 32'h0000_0000;
			link.ack_time <= 32'h0000_0000;
			after_null <= 1'b0;
			last_ofs <= 14'h0000;
		end else begin
			link.map_start <= new_map;
			if (new_map) begin
				link.alloc_start <= alloc_start_in & time_mask;
				link.ack_time <= ack_time_in & time_mask;
				after_null <= 1'b0;
				last_ofs <= 14'h0000;
			end else if (sent) begin
				if (el_iuc == alloc_map_pkg::IUC_NULL)
					after_null <= 1'b1;
				if (el_last)
					after_null <= 1'b0;
				last_ofs <= el_ofs;
			end
		end
	end
endmodule : map_ie_scheduler
`default_nettype wire

// File: alloc_map_chk.sv
// Concurrent checks on the map link between headend and modem
`timescale 1ns/100ps
`default_nettype none
module alloc_map_chk (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic map_start,
	input wire logic [31:0] alloc_start,
	input wire logic ie_valid,
	input wire logic ie_ready,
	input wire logic [31:0] ie_word,
	input wire logic ie_last
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire logic take = ie_valid && ie_ready && !map_start;
	wire logic [3:0] iuc = ie_word[17:14];
	wire logic [13:0] sid = ie_word[31:18];
	wire logic [13:0] ofs = ie_word[13:0];
	logic in_map;
	logic past_null;
	logic [13:0] last_ofs;
	// ********************************
	// Map tracking
	// ********************************
	always_ff @(posedge sys_clk) begin
		if (!rst_n || map_start) begin
			in_map <= rst_n && map_start;
			past_null <= 1'b0;
			last_ofs <= 14'h0;
		end else if (take) begin
			in_map <= !ie_last;
			past_null <= past_null || iuc == 4'h7;
			last_ofs <= ofs;
		end
	end
	property p_ready; $past(rst_n) |-> ie_ready; endproperty
	a_ready: assert property (p_ready) else $error("modem stopped accepting");
	property p_in_map; ie_valid && !map_start |-> in_map; endproperty
	a_in_map: assert property (p_in_map) else $error("element outside a map");
	property p_ascend; take && !past_null |-> ofs >= last_ofs; endproperty
	a_ascend: assert property (p_ascend) else $error("offsets not ascending");
	property p_after_null; take && past_null |-> iuc inside {4'h5, 4'h6, 4'h8, 4'h9, 4'ha}; endproperty
	a_after_null: assert property (p_after_null) else $error("allocation after null");
	property p_null_close; take && ie_last |-> past_null || iuc == 4'h7; endproperty
	a_null_close: assert property (p_null_close) else $error("map without null");
	property p_reqdata; take && iuc == 4'h2 |-> sid >= 14'h2000 && sid != 14'h3fff; endproperty
	a_reqdata: assert property (p_reqdata) else $error("request/data not multicast");
	property p_start_hold; $changed(alloc_start) |-> map_start || $past(map_start); endproperty
	a_start_hold: assert property (p_start_hold) else $error("start time moved in map");
	property p_start_pulse; map_start |=> !map_start [*2]; endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("map start not a pulse");
endmodule : alloc_map_chk
`default_nettype wire

// File: tb_top.sv
// Bench joining the headend and modem ends of the map link
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_top;
	typedef struct packed {logic [13:0] sid; logic [3:0] iuc; logic [13:0] ofs; logic [13:0] len;} exp_t;
	logic sys_clk = 1'b0, rst_n = 1'b0, new_map = 1'b0, el_valid = 1'b0, el_last = 1'b0;
	logic adv_only = 1'b0, legacy = 1'b0, ack_wanted = 1'b0;
	logic mixed = 1'b0, cm_adv = 1'b1, adv_def = 1'b0, short_def = 1'b0;
	logic [13:0] short_max = 14'h10;
	logic [4:0] time_m = 5'h0;
	logic [13:0] el_sid = 14'h0, el_ofs = 14'h0, el_len = 14'h0, own_sid = 14'h1, rng_ofs = 14'h0;
	logic [3:0] el_iuc = 4'h0;
	logic [31:0] a_start = 32'h0;
	wire logic [31:0] tmask = 32'h3ffffff >> time_m;
	wire logic el_ready, el_reject, ivl_valid, grant_pending, data_acked, expansion_seen;
	wire logic ivl_for_me, ivl_ack_req, ivl_sizes_req;
	wire logic [31:0] ivl_start, ivl_launch, eff_ack_time;
	wire logic [13:0] ivl_sid, ivl_len;
	wire logic [3:0] ivl_iuc, ivl_fmt;
	wire logic [1:0] ivl_class;
	wire logic [31:0] eff_map_start;
	int bad_count = 0, n_tests = 0, n_gp = 0, n_ack = 0, n_exp = 0, x_ack = 0, w;
	logic [13:0] ofs [8];
	exp_t e;
	exp_t exp_q [$];
	alloc_map_if link_if();
	map_ie_scheduler map_ie_scheduler_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(link_if), .new_map(new_map),
		.alloc_start_in(a_start), .ack_time_in(~a_start), .time_m(time_m), .el_valid(el_valid), .el_ready(el_ready),
		.el_sid(el_sid), .el_iuc(el_iuc), .el_ofs(el_ofs), .el_last(el_last), .adv_only_upstream(adv_only),
		.mixed_channel(mixed), .cm_advanced(cm_adv), .adv_codes_defined(adv_def), .short_defined(short_def),
		.short_max(short_max), .el_len(el_len), .el_reject(el_reject));
	map_ie_decoder map_ie_decoder_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(link_if), .own_sid(own_sid),
		.legacy_mode(legacy), .ack_wanted(ack_wanted), .time_m(time_m), .ranging_offset(rng_ofs),
		.ivl_valid(ivl_valid), .ivl_sid(ivl_sid), .ivl_iuc(ivl_iuc), .ivl_class(ivl_class), .ivl_start(ivl_start),
		.ivl_launch(ivl_launch), .ivl_len(ivl_len), .ivl_fmt(ivl_fmt), .ivl_for_me(ivl_for_me),
		.ivl_ack_req(ivl_ack_req), .ivl_sizes_req(ivl_sizes_req),
		.grant_pending(grant_pending), .data_acked(data_acked), .expansion_seen(expansion_seen),
		.eff_map_start(eff_map_start), .eff_ack_time(eff_ack_time));
	alloc_map_chk alloc_map_chk_i (.sys_clk(sys_clk), .rst_n(rst_n), .map_start(link_if.map_start),
		.alloc_start(link_if.alloc_start), .ie_valid(link_if.ie_valid), .ie_ready(link_if.ie_ready),
		.ie_word(link_if.ie_word), .ie_last(link_if.ie_last));
	always #50 sys_clk = ~sys_clk;
	function automatic logic [1:0] cls(input logic [13:0] s);
		return (s == 14'h3fff) ? 2'h3 : (s >= 14'h2000) ? 2'h2 : (s != 14'h0) ? 2'h1 : 2'h0;
	endfunction : cls
	function automatic logic [3:0] fmt(input logic [3:0] c);
		return (c == 4'h1) ? 4'h1 : (c == 4'h2) ? 4'h3 : (c == 4'h3) ? 4'hc : 4'h4;
	endfunction : fmt
	// Broadcast and multicast intervals are open to every modem
	function automatic logic mine(input logic [13:0] s);
		return s == own_sid || s >= 14'h2000;
	endfunction : mine
	function automatic logic grant(input logic [3:0] c);
		return c == 4'h5 || c == 4'h6 || c == 4'h9 || c == 4'ha;
	endfunction : grant
	function automatic logic [31:0] start_of(input logic [13:0] o);
		return ((a_start & tmask) + 32'(o)) & tmask;
	endfunction : start_of
	// ********************************
	// Modem side monitor
	// ********************************
	always @(posedge sys_clk) begin
		if (rst_n === 1'b1) begin
			n_gp += (grant_pending === 1'b1);
			n_ack += (data_acked === 1'b1);
			n_exp += (expansion_seen === 1'b1);
			// Intervals past the queue, such as the expansion element, are not compared here
			if (ivl_valid === 1'b1 && exp_q.size() > 0) begin
				e = exp_q.pop_front();
				`CHK("sid", e.sid, ivl_sid)
				`CHK("iuc", e.iuc, ivl_iuc)
				`CHK("class", cls(e.sid), ivl_class)
				`CHK("len", e.len, ivl_len)
				if (e.iuc < 4'h5) `CHK("fmt", mine(e.sid) ? fmt(e.iuc) : 4'h0, ivl_fmt)
				`CHK("me", mine(e.sid), ivl_for_me)
				`CHK("ackreq", e.iuc == 4'h2, ivl_ack_req)
				`CHK("sizes", grant(e.iuc) && !legacy, ivl_sizes_req)
				`CHK("start", start_of(e.ofs), ivl_start)
				`CHK("launch", (start_of(e.ofs) - 32'(rng_ofs)) & tmask, ivl_launch)
				if (legacy && e.iuc > 4'h8) `CHK("advfmt", 4'h0, ivl_fmt)
			end
		end
	end
	task automatic send(input logic [13:0] s, input logic [3:0] c, input logic [13:0] o, l, input logic z,
		output logic rej);
		{el_sid, el_iuc, el_ofs, el_len, el_last, el_valid} = {s, c, o, l, z, 1'b1};
		#5 rej = el_reject;
		w = 0;
		do begin
			@(posedge sys_clk);
			w++;
		end while (el_ready !== 1'b1 && w < 20);
		#1;
	endtask : send
	task automatic run_map(input int idx);
		logic [3:0] iucs [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'ha, 4'hb};
		logic [13:0] corner [6] = '{14'h3fff, 14'h3ffe, 14'h2000, 14'h1fff, 14'h1, 14'h0};
		logic [13:0] s;
		logic [3:0] c;
		logic r;
		int n;
		n = (idx == 0) ? 6 : 1 + $urandom % 5;
		{adv_only, legacy, ack_wanted, time_m} = 8'($urandom);
		own_sid = 14'h1 + 14'($urandom % 14'h1ffe);
		rng_ofs = 14'($urandom);
		a_start = $urandom;
		ofs[0] = 14'($urandom % 8);
		for (int k = 0; k < n; k++) ofs[k + 1] = ofs[k] + 14'h1 + 14'($urandom % 20);
		new_map = 1'b1;
		@(posedge sys_clk);
		#1 new_map = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		if (idx == 0) begin
			adv_only = 1'b0;
			send(14'h5, 4'h2, 14'h0, 14'h1, 1'b0, r);
			`CHK("rej_rd", 1'b1, r)
			send(14'h5, 4'h3, 14'h0, 14'h1, 1'b0, r);
			`CHK("rej_im", 1'b1, r)
			send(14'h5, 4'h1, 14'h0, 14'h1, 1'b1, r);
			`CHK("rej_open", 1'b1, r)
			short_def = 1'b1;
			send(14'h5, 4'h6, 14'h0, 14'h8, 1'b0, r);
			`CHK("rej_long", 1'b1, r)
			{short_def, mixed, cm_adv} = 3'b010;
			send(14'h5, 4'h9, 14'h0, 14'h1, 1'b0, r);
			`CHK("rej_mix", 1'b1, r)
			send(14'h5, 4'hb, 14'h0, 14'h1, 1'b0, r);
			`CHK("rej_ugs", 1'b1, r)
			{cm_adv, adv_def} = 2'b11;
			send(14'h5, 4'h5, 14'h0, 14'h1, 1'b0, r);
			`CHK("rej_adv", 1'b1, r)
			{mixed, adv_def} = 2'b00;
		end
		for (int k = 0; k < n; k++) begin
			c = (idx == 0) ? 4'h1 : iucs[$urandom % 9];
			s = (idx == 0) ? corner[k] : (c == 4'h3) ? 14'h3fff : (c == 4'h2) ? 14'h2000 + 14'($urandom % 14'h1ffe) : own_sid;
			send(s, c, ofs[k], ofs[k + 1] - ofs[k], 1'b0, r);
			`CHK("acc", 1'b0, r)
			exp_q.push_back({s, c, ofs[k], 14'(ofs[k + 1] - ofs[k])});
		end
		if (idx == 0) begin
			send(14'h5, 4'h1, 14'h0, 14'h1, 1'b0, r);
			`CHK("rej_ord", 1'b1, r)
		end
		send(14'h0, 4'hf, ofs[n], 14'h0, 1'b0, r);
		send(14'h0, 4'h7, ofs[n], 14'h0, 1'b0, r);
		if (idx == 0) begin
			send(own_sid, 4'h1, ofs[n], 14'h0, 1'b0, r);
			`CHK("rej_tail", 1'b1, r)
		end
		send(own_sid, 4'h5, ofs[n], 14'h0, 1'b0, r);
		send(own_sid, 4'h8, ofs[n], 14'h0, 1'b1, r);
		el_valid = 1'b0;
		x_ack += ack_wanted;
		repeat (4) @(posedge sys_clk);
		#1;
		`CHK("eff", a_start & tmask, eff_map_start)
		`CHK("eff_ack", ~a_start & tmask, eff_ack_time)
		`CHK("pend", idx + 1, n_gp)
		`CHK("ack", x_ack, n_ack)
		`CHK("expn", idx + 1, n_exp)
		`CHK("left", 0, exp_q.size())
		$display("map %0d done", idx);
	endtask : run_map
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		void'($urandom(32'h7d30));
		repeat (5) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		for (int i = 0; i < 30; i++) run_map(i);
		complete_run();
	end
	// Thirty maps take well under a thousand cycles
	initial begin
		#(100 * 5000);
		bad_count++;
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
